/* mcb_pkg.sv */
// Package of constants and carrier types for the maintenance control byte
package mcb_pkg;
    // ------------------------------------------------------------------
    // Register placement and bit layout
    // ------------------------------------------------------------------
    localparam logic [2:0] MCB_WORD_OFFSET = 3'h0;
    localparam int MCB_BIT_STEP = 0;
    localparam int MCB_BIT_INJECT = 1;
    localparam int MCB_BIT_READOUT = 2;
    localparam int MCB_BIT_LOOP = 3;
    localparam int MCB_BIT_SHIFT = 4;
    localparam int MCB_BIT_RSVD = 5;
    localparam int MCB_BIT_CLEAR = 6;
    localparam int MCB_BIT_RUN = 7;
    localparam logic [7:0] MCB_RESET_VALUE = 8'h80;
    localparam logic [7:0] MCB_FUNC_MASK = 8'h1F;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int MCB_CLK_HZ = 10_000_000;
    localparam int MCB_STEP_PULSES = 5;
    localparam int MCB_PULSE_NS = 60;
    localparam int MCB_PULSE_CYC_RAW = (MCB_PULSE_NS * MCB_CLK_HZ
                                        + 999_999_999) / 1_000_000_000;
    localparam int MCB_PULSE_CYC = (MCB_PULSE_CYC_RAW < 1) ? 1
                                   : MCB_PULSE_CYC_RAW;
    localparam int MCB_MODEM_BPS = 10_000;
    localparam int MCB_COAX_BPS = 20_000;
    localparam int MCB_MODEM_DIV = MCB_CLK_HZ / MCB_MODEM_BPS;
    localparam int MCB_COAX_DIV = MCB_CLK_HZ / MCB_COAX_BPS;
    localparam int MCB_DIV_W = 10;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic run;
        logic clear;
        logic rsvd;
        logic shift;
        logic loop;
        logic readout;
        logic inject;
        logic step;
    } mcb_ctrl_s;

    typedef struct packed {
        logic shift_tx;
        logic shift_rx;
        logic loop;
        logic init;
    } mcb_line_s;

    typedef enum logic [1:0] {
        MCB_CLK_LINE = 2'h0,
        MCB_CLK_STROBE = 2'h1,
        MCB_CLK_MAINT = 2'h2
    } mcb_clksrc_e;
endpackage

/* mcb_step_gen.sv */
// Single-instruction step sequencer: five timed clock pulses per request
`timescale 1ns/10ps
module mcb_step_gen
    import mcb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start,
    output logic pulse,
    output logic busy
);
    // ------------------------------------------------------------------
    // Pulse sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MCB_SG_IDLE = 2'h0,
        MCB_SG_HIGH = 2'h1,
        MCB_SG_LOW = 2'h2
    } mcb_sg_e;

    mcb_sg_e state;
    mcb_sg_e next_state;
    logic [2:0] npulse;
    logic [2:0] next_npulse;

    // Each pulse is one high cycle and one low cycle, at least 60 ns each
    always_comb begin
        next_state = state;
        next_npulse = npulse;
        unique case (state)
            MCB_SG_IDLE: begin
                if (start) begin
                    next_state = MCB_SG_HIGH;
                    next_npulse = 3'h0;
                end
            end
            MCB_SG_HIGH: begin
                next_state = MCB_SG_LOW;
                next_npulse = npulse + 3'h1;
            end
            MCB_SG_LOW: begin
                if (npulse == 3'(MCB_STEP_PULSES)) begin // [R5]
                    next_state = MCB_SG_IDLE;
                end else begin
                    next_state = MCB_SG_HIGH;
                end
            end
            default: next_state = MCB_SG_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= MCB_SG_IDLE;
            npulse <= 3'h0;
        end else begin
            state <= next_state;
            npulse <= next_npulse;
        end
    end

    assign pulse = (state == MCB_SG_HIGH);
    assign busy = (state != MCB_SG_IDLE);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Last pulse is followed by its low cycle, then the sequencer idles
    step_five_a: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!rst_b)
        (state == MCB_SG_IDLE && start) |=> pulse ##2 pulse ##2 pulse
        ##2 pulse ##2 pulse ##2 !busy)
        else $error("step did not give five pulses");
endmodule

/* mcb_maint_ctrl.sv */
// Maintenance control byte: halt, step, store readout, inject, loopback
// Operation
// [R1] Byte is the high byte of the controller's first word address.
// [R2] Every bit of the byte reads back and writes from the host.
// [R3] Lock-out switch on: only full_initialize acts, others ignored.
// [R4] Maintenance functions override every other controller control.
// [R5] Step runs one instruction of five 60 ns clock pulses.
// [R6] Host should clear run before using single step.
// [R7] Inject set: step executes data bytes six/seven instead of store.
// [R8] Readout set: data bytes four to seven return addressed store word.
// [R9] Readout with step: bytes four to seven show next store address.
// [R10] Loopback routes line serial out to serial in at logic level.
// [R11] Loopback, run clear: shift strobe is the only serial clock.
// [R12] Loopback, run set: maintenance clock, 10k modem or 20k coax.
// [R13] Loopback clear, run set: normal line, external clocking; code does so only with coax_unit set, else maintenance clock.
// [R14] Shift strobe high shifts transmitter, low shifts receiver.
// [R15] Full initialize resets sequencer, line, sets run, self clears.
// [R16] Run gates sequencer clock; set by bus init or full initialize.
`timescale 1ns/10ps
module mcb_maint_ctrl
    import mcb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bus_init,
    input wire logic sel,
    input wire logic [2:0] word_addr,
    input wire logic wr_hi,
    input wire logic rd,
    input wire logic [7:0] wdata_hi,
    output logic [7:0] rdata_hi,
    input wire logic lock_out_pin,
    input wire logic coax_unit,
    input wire logic [31:0] store_word,
    input wire logic [31:0] next_store_addr,
    input wire logic [31:0] data_bytes_normal,
    input wire logic [15:0] data_byte_six_seven,
    output logic [31:0] data_bytes_rd,
    input wire logic ctl_seq_clk_en,
    input wire logic ctl_seq_clear,
    output logic seq_clk_en,
    output logic seq_init,
    output logic [15:0] seq_word,
    output logic seq_use_inject,
    input wire logic line_tx_out,
    input wire logic ext_rx_in,
    input wire logic ext_line_clk,
    output logic line_rx_in,
    output mcb_line_s line_ctl,
    output mcb_clksrc_e clk_src
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;

    // Lock-out switch, external data and clock come from outside
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {lock_out_pin, ext_rx_in, ext_line_clk};
            sync_b <= sync_a;
        end
    end

    logic lock_out;
    logic ext_rx;
    logic ext_clk;
    assign lock_out = sync_b[2];
    assign ext_rx = sync_b[1];
    assign ext_clk = sync_b[0];

    // ------------------------------------------------------------------
    // Control byte register
    // ------------------------------------------------------------------
    mcb_ctrl_s ctrl;
    mcb_ctrl_s next_ctrl;
    logic hit;
    logic step_start;
    logic step_busy;
    logic step_pulse;
    logic step_q;

    // Decode matches the first word of the controller
    function automatic logic word_hit(input logic s, input logic [2:0] a);
        word_hit = s && (a == MCB_WORD_OFFSET);
    endfunction

    assign hit = word_hit(sel, word_addr); // [R1]

    // Writes store every bit; clear self-clears the cycle after it acts
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl.clear) begin
            next_ctrl.clear = 1'b0; // [R15]
        end
        if (hit && wr_hi) begin
            next_ctrl = mcb_ctrl_s'(wdata_hi); // [R2]
        end
        if (ctrl.clear || bus_init) begin
            next_ctrl.run = 1'b1; // [R15] [R16]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= mcb_ctrl_s'(MCB_RESET_VALUE);
            step_q <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            step_q <= ctrl.step;
        end
    end

    // Read returns the stored byte as written
    assign rdata_hi = (hit && rd) ? ctrl : 8'h00; // [R2]

    // ------------------------------------------------------------------
    // Effective functions under the lock-out switch
    // ------------------------------------------------------------------
    mcb_ctrl_s act;
    // Bits remain readable but lose effect; only clear still acts, and
    // run is held on so a locked-out controller cannot be halted
    always_comb begin
        act = ctrl;
        if (lock_out) begin
            act = mcb_ctrl_s'(ctrl & ~MCB_FUNC_MASK); // [R3]
            act.run = 1'b1; // [R3]
        end
    end

    // ------------------------------------------------------------------
    // Sequencer clock, step, inject and readout
    // ------------------------------------------------------------------
    // Step launches on the rising edge of the bit so it runs only once
    assign step_start = act.step && !step_q && !step_busy; // [R5]

    mcb_step_gen u_step (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(step_start),
        .pulse(step_pulse),
        .busy(step_busy)
    );

    // Maintenance wins over the normal controller's clock and clear
    always_comb begin
        if (act.run) begin
            seq_clk_en = ctl_seq_clk_en; // [R16]
        end else begin
            seq_clk_en = step_pulse; // [R4] [R5]
        end
        seq_init = ctrl.clear || (ctl_seq_clear && !act.step); // [R15] [R4]
        seq_use_inject = act.inject && step_busy; // [R7]
    end

    // Injected word is reloaded every cycle while inject is set, held otherwise
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_word <= 16'h0000;
        end else if (act.inject) begin
            seq_word <= data_byte_six_seven; // [R7]
        end
    end

    // Readout replaces data bytes four to seven; step shows next address
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_bytes_rd <= 32'h00000000;
        end else if (act.readout && act.step) begin
            data_bytes_rd <= next_store_addr; // [R9]
        end else if (act.readout) begin
            data_bytes_rd <= store_word; // [R8]
        end else begin
            data_bytes_rd <= data_bytes_normal;
        end
    end

    // ------------------------------------------------------------------
    // Line unit clocking and loopback
    // ------------------------------------------------------------------
    logic [MCB_DIV_W-1:0] div;
    logic [MCB_DIV_W-1:0] next_div;
    logic [MCB_DIV_W-1:0] div_top;
    logic maint_tick;
    logic ext_q;
    logic shift_q;

    assign div_top = coax_unit ? MCB_DIV_W'(MCB_COAX_DIV - 1)
                               : MCB_DIV_W'(MCB_MODEM_DIV - 1); // [R12]
    // At or past the top, so a change of line unit cannot overrun the count
    assign maint_tick = (div >= div_top);

    always_comb begin
        next_div = maint_tick ? '0 : div + 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div <= '0;
            ext_q <= 1'b0;
            shift_q <= 1'b0;
        end else begin
            div <= next_div;
            ext_q <= ext_clk;
            shift_q <= act.shift;
        end
    end

    // Pick the clock source from loopback, run and the line unit type
    always_comb begin
        if (act.loop && !act.run) begin
            clk_src = MCB_CLK_STROBE; // [R11]
        end else if (act.loop || !coax_unit) begin
            clk_src = MCB_CLK_MAINT; // [R12] [R13]
        end else begin
            clk_src = MCB_CLK_LINE; // [R13]
        end
    end

    // Strobe edges: rising shifts transmitter, falling shifts receiver
    always_comb begin
        line_ctl.loop = act.loop;
        line_ctl.init = ctrl.clear; // [R15]
        unique case (clk_src)
            MCB_CLK_STROBE: begin
                line_ctl.shift_tx = act.shift && !shift_q; // [R14]
                line_ctl.shift_rx = !act.shift && shift_q; // [R14]
            end
            MCB_CLK_MAINT: begin
                line_ctl.shift_tx = maint_tick;
                line_ctl.shift_rx = maint_tick;
            end
            default: begin
                line_ctl.shift_tx = ext_clk && !ext_q;
                line_ctl.shift_rx = !ext_clk && ext_q;
            end
        endcase
        // Loop taken on logic levels, ahead of any level converter
        line_rx_in = act.loop ? line_tx_out : ext_rx; // [R10]
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    write_back_a: assert property ( // [R2]
        @(posedge sys_clk) disable iff (!rst_b)
        (hit && wr_hi && !bus_init && !ctrl.clear && !wdata_hi[MCB_BIT_CLEAR])
        |=> ctrl == $past(wdata_hi))
        else $error("written byte not stored");
    clear_self_a: assert property ( // [R15]
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl.clear |=> ctrl.run && (!ctrl.clear || $past(hit && wr_hi)))
        else $error("full initialize did not self clear");
    lock_ignore_a: assert property ( // [R3]
        @(posedge sys_clk) disable iff (!rst_b)
        lock_out |-> !line_ctl.loop && !seq_use_inject)
        else $error("function active under lock-out");
    loop_route_a: assert property ( // [R10]
        @(posedge sys_clk) disable iff (!rst_b)
        act.loop |-> line_rx_in == line_tx_out)
        else $error("loopback not routed");
    strobe_only_a: assert property ( // [R11]
        @(posedge sys_clk) disable iff (!rst_b)
        (act.loop && !act.run) |-> clk_src == MCB_CLK_STROBE)
        else $error("strobe not sole clock");
    maint_clk_a: assert property ( // [R12]
        @(posedge sys_clk) disable iff (!rst_b)
        (act.loop && act.run) |-> clk_src == MCB_CLK_MAINT)
        else $error("maintenance clock not selected");
    halt_clk_a: assert property ( // [R16]
        @(posedge sys_clk) disable iff (!rst_b)
        (!act.run && !step_busy) |-> !seq_clk_en)
        else $error("sequencer clock while halted");
    readout_a: assert property ( // [R8]
        @(posedge sys_clk) disable iff (!rst_b)
        (act.readout && !act.step) |=> data_bytes_rd == $past(store_word))
        else $error("readout not returned");
    next_addr_a: assert property ( // [R9]
        @(posedge sys_clk) disable iff (!rst_b)
        (act.readout && act.step) |=> data_bytes_rd == $past(next_store_addr))
        else $error("next address not shown");
    bus_init_a: assert property ( // [R16]
        @(posedge sys_clk) disable iff (!rst_b)
        bus_init |=> ctrl.run)
        else $error("bus init did not set run");
    lock_run_a: assert property ( // [R3]
        @(posedge sys_clk) disable iff (!rst_b)
        lock_out |-> seq_clk_en == ctl_seq_clk_en)
        else $error("run bit acted under lock-out");
    clear_init_a: assert property ( // [R15]
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl.clear |-> seq_init && line_ctl.init)
        else $error("full initialize did not reach sequencer and line");
    strobe_tx_a: assert property ( // [R14]
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_src == MCB_CLK_STROBE && line_ctl.shift_tx)
        |-> act.shift && !line_ctl.shift_rx)
        else $error("transmitter shifted without strobe");

    step_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        step_start ##1 step_busy);
    inject_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        seq_use_inject && step_pulse);
    loop_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        act.loop && line_ctl.shift_rx);
    lock_clear_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        lock_out && ctrl.clear);
endmodule

/* mcb_host.sv */
// Host program model that reaches the maintenance byte over the bus
`timescale 1ns/10ps
module mcb_host (
    input wire logic sys_clk,
    output logic sel,
    output logic [2:0] word_addr,
    output logic wr_hi,
    output logic rd,
    output logic [7:0] wdata_hi,
    input wire logic [7:0] rdata_hi
);
    // Idle bus: data shows the inverse of the last value, never a copy
    initial begin
        sel = 1'b0;
        word_addr = 3'h7;
        wr_hi = 1'b0;
        rd = 1'b0;
        wdata_hi = 8'h00;
    end

    // One-cycle write strobe; qualifiers held up to the sampling edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        sel = 1'b1;
        word_addr = a;
        wdata_hi = d;
        wr_hi = 1'b1;
        @(posedge sys_clk);
        #1;
        sel = 1'b0;
        wr_hi = 1'b0;
        word_addr = ~a;
        wdata_hi = ~d;
    endtask

    // Read data is combinational, so it is taken mid-cycle
    task automatic rdb(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        sel = 1'b1;
        rd = 1'b1;
        word_addr = a;
        @(negedge sys_clk);
        d = rdata_hi;
        @(posedge sys_clk);
        #1;
        sel = 1'b0;
        rd = 1'b0;
        word_addr = ~a;
    endtask
endmodule

/* mcb_tb.sv */
// Self-checking testbench of the maintenance control byte
`timescale 1ns/10ps
module testbench
    import mcb_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic bus_init = 1'b0;
    logic lock = 1'b0;
    logic en = 1'b1;
    logic tx = 1'b0;
    logic ext_rx = 1'b0;
    logic coax = 1'b0;
    logic ext_clk = 1'b0;
    logic sel, wr_hi, rd, use_inj, clk_en, s_init, rx_in;
    logic [2:0] word_addr;
    logic [7:0] wdata, rdata, b;
    logic [31:0] bytes_rd;
    logic [15:0] seq_word;
    mcb_line_s line_ctl;
    mcb_clksrc_e clk_src;
    int miscompares = 0;
    int tests_run = 0;
    int n_clk, n_tx, n_rx, n_init, n_inj;

    always #50 sys_clk = ~sys_clk;

    mcb_host host (.sys_clk(sys_clk), .sel(sel), .word_addr(word_addr),
        .wr_hi(wr_hi), .rd(rd), .wdata_hi(wdata), .rdata_hi(rdata));

    mcb_maint_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .bus_init(bus_init), .sel(sel), .word_addr(word_addr),
        .wr_hi(wr_hi), .rd(rd), .wdata_hi(wdata), .rdata_hi(rdata),
        .lock_out_pin(lock), .coax_unit(coax),
        .store_word(32'h11223344), .next_store_addr(32'h00000123),
        .data_bytes_normal(32'hCAFEBABE), .data_byte_six_seven(16'hA5C3),
        .data_bytes_rd(bytes_rd), .ctl_seq_clk_en(en),
        .ctl_seq_clear(1'b0), .seq_clk_en(clk_en), .seq_init(s_init),
        .seq_word(seq_word), .seq_use_inject(use_inj),
        .line_tx_out(tx), .ext_rx_in(ext_rx), .ext_line_clk(ext_clk),
        .line_rx_in(rx_in), .line_ctl(line_ctl), .clk_src(clk_src));

    // Pulse counters, sampled mid-cycle where outputs have settled
    always @(negedge sys_clk) begin
        if (clk_en === 1'b1) n_clk++;
        if (line_ctl.shift_tx === 1'b1) n_tx++;
        if (line_ctl.shift_rx === 1'b1) n_rx++;
        if (s_init === 1'b1 && line_ctl.init === 1'b1) n_init++;
        if (use_inj === 1'b1) n_inj++;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic summarize();
        $display("compares=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Wait whole cycles, then step off the edge so outputs have settled
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Reset value, decode and read/write of the values A0 and 00
    task automatic t_regs();
        host.rdb(3'h0, b);
        chk(b, 8'h80);
        host.rdb(3'h1, b);
        chk(b, 8'h00);
        host.wr(3'h0, 8'hA0);
        host.rdb(3'h0, b);
        chk(b, 8'hA0);
        host.wr(3'h1, 8'hFF);
        host.rdb(3'h0, b);
        chk(b, 8'hA0);
        host.wr(3'h0, 8'h00);
        host.rdb(3'h0, b);
        chk(b, 8'h00);
    endtask

    // Halted sequencer: a step gives exactly five clock pulses
    task automatic t_step();
        host.wr(3'h0, 8'h00);
        n_clk = 0;
        host.wr(3'h0, 8'h01);
        wait_cyc(14);
        chk(n_clk, 5);
        n_inj = 0;
        host.wr(3'h0, 8'h02);
        host.wr(3'h0, 8'h03);
        wait_cyc(14);
        chk(seq_word, 16'hA5C3);
        // Inject stands for the whole step: five pulses of two cycles
        chk(n_inj, 10);
    endtask

    // Source of data bytes four to seven in each readout mode
    task automatic t_readout();
        host.wr(3'h0, 8'h00);
        wait_cyc(2);
        chk(bytes_rd, 32'hCAFEBABE);
        host.wr(3'h0, 8'h04);
        wait_cyc(2);
        chk(bytes_rd, 32'h11223344);
        host.wr(3'h0, 8'h05);
        wait_cyc(14);
        chk(bytes_rd, 32'h00000123);
    endtask

    // Internal loop with strobe clock, then maintenance and line clocks
    task automatic t_loop();
        host.wr(3'h0, 8'h08);
        tx = 1'b1;
        wait_cyc(1);
        chk(rx_in, 1'b1);
        tx = 1'b0;
        wait_cyc(1);
        chk(rx_in, 1'b0);
        chk(clk_src, MCB_CLK_STROBE);
        chk(line_ctl.loop, 1'b1);
        n_tx = 0;
        host.wr(3'h0, 8'h18);
        wait_cyc(4);
        chk(n_tx, 1);
        n_rx = 0;
        host.wr(3'h0, 8'h08);
        wait_cyc(4);
        chk(n_rx, 1);
        host.wr(3'h0, 8'h88);
        chk(clk_src, MCB_CLK_MAINT);
        // 10 kbit/s at 100 ns per cycle: 3000 cycles carry three bits
        n_tx = 0;
        n_rx = 0;
        wait_cyc(3000);
        chk(n_tx, 3);
        chk(n_rx, 3);
        // 20 kbit/s: 2000 cycles carry four bits once the rate has settled
        coax = 1'b1;
        wait_cyc(2);
        n_tx = 0;
        wait_cyc(2000);
        chk(n_tx, 4);
        host.wr(3'h0, 8'h80);
        chk(clk_src, MCB_CLK_LINE);
        n_tx = 0;
        n_rx = 0;
        ext_clk = 1'b1;
        wait_cyc(4);
        ext_clk = 1'b0;
        ext_rx = 1'b1;
        wait_cyc(4);
        chk(n_tx, 1);
        chk(n_rx, 1);
        chk(rx_in, 1'b1);
        coax = 1'b0;
        wait_cyc(1);
        chk(clk_src, MCB_CLK_MAINT);
    endtask

    // Lock-out: bits stored but idle, full initialize still acts
    task automatic t_lock();
        lock = 1'b1;
        wait_cyc(3);
        host.wr(3'h0, 8'h08);
        host.rdb(3'h0, b);
        chk(b, 8'h08);
        chk(line_ctl.loop, 1'b0);
        // Run was written clear, yet the controller keeps its own clock
        chk(clk_en, 1'b1);
        en = 1'b0;
        wait_cyc(1);
        chk(clk_en, 1'b0);
        en = 1'b1;
        n_init = 0;
        host.wr(3'h0, 8'h48);
        repeat (3) @(posedge sys_clk);
        chk(n_init, 1);
        host.rdb(3'h0, b);
        chk(b, 8'h88);
        lock = 1'b0;
    endtask

    // Run set again by full initialize and by bus initialization
    task automatic t_init();
        host.wr(3'h0, 8'h00);
        n_init = 0;
        host.wr(3'h0, 8'h40);
        repeat (3) @(posedge sys_clk);
        chk(n_init, 1);
        host.rdb(3'h0, b);
        chk(b, 8'h80);
        host.wr(3'h0, 8'h00);
        @(posedge sys_clk);
        #1 bus_init = 1'b1;
        @(posedge sys_clk);
        #1 bus_init = 1'b0;
        host.rdb(3'h0, b);
        chk(b, 8'h80);
    endtask

    // Hang guard: a run this long counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        t_regs();
        t_step();
        t_readout();
        t_loop();
        t_lock();
        t_init();
        summarize();
    end
endmodule
